/* File: verilog/dbs_pkg.sv */
package dbs_pkg;

    // Avalon byte offsets of the two registers.
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;

    // Control register field positions.
    localparam int CTRL_HS = 0;
    localparam int CTRL_CIS = 1;
    localparam int CTRL_ENTER = 2;
    localparam int CTRL_GO = 3;

    // Status register field positions.
    localparam int STAT_ACT = 0;
    localparam int STAT_STOP = 1;
    localparam int STAT_WAIT = 2;
    localparam int STAT_NR = 3;
    localparam int STAT_LACK = 4;

    // Values after reset.
    localparam logic HS_RST = 1'b0;
    localparam logic CIS_RST = 1'b0;

    // Length of the long acknowledge pulse in core cycles.
    localparam logic [4:0] LACK_CYC = 5'h10;

    // Link command codes.
    typedef enum logic [1:0]
    {
        OP_READ = 2'b00,
        OP_WRITE = 2'b01,
        OP_STEP = 2'b10,
        OP_NONE = 2'b11
    } dbs_op_e;

    // Internal access sequencer states.
    typedef enum logic [1:0]
    {
        A_IDLE = 2'b00,
        A_DEC = 2'b01,
        A_ARB = 2'b10,
        A_BUS = 2'b11
    } dbs_acc_e;

    // Execution control states.
    typedef enum logic [2:0]
    {
        S_USER = 3'b000,
        S_ACTIVE = 3'b001,
        S_RUN = 3'b010,
        S_STOP = 3'b011,
        S_WAIT = 3'b100
    } dbs_step_e;

endpackage

/* File: verilog/dbs_debug_step.sv */
`timescale 1ns/1ns
module dbs_debug_step
(
    input logic i_mclk,
    input logic i_rst,
    input logic [3:0] i_avs_address,
    input logic i_avs_read,
    input logic i_avs_write,
    input logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input logic i_dsclk,
    input logic i_lnk_cmd_stb,
    input logic [1:0] i_lnk_op,
    input logic [15:0] i_lnk_addr,
    input logic [7:0] i_lnk_data,
    input logic i_lnk_fetch_stb,
    output logic [7:0] o_lnk_rdata,
    output logic o_lnk_rvalid,
    output logic o_bus_req,
    output logic o_bus_we,
    output logic [15:0] o_bus_addr,
    output logic [7:0] o_bus_wdata,
    input logic i_bus_free,
    input logic i_bus_ready,
    input logic [7:0] i_bus_rdata,
    output logic o_dbg_active,
    output logic o_freeze,
    output logic o_cpu_step,
    input logic i_cpu_retire,
    input logic i_cpu_stop,
    input logic i_cpu_wait,
    input logic i_irq_wake,
    output logic o_long_ack
);

    logic lr_s1_q, lr_s2_q;
    logic [1:0] l_op_q;
    logic [15:0] l_addr_q;
    logic [7:0] l_data_q, l_rdata_q, rdata_q;
    logic l_rq_q, l_fe_q, l_dn1_q, l_dn2_q, l_dn3_q, l_rv_q;
    logic rq1_q, rq2_q, rq3_q, fe1_q, fe2_q, fe3_q, dn_q;
    dbs_pkg::dbs_acc_e acc_q, acc_d;
    dbs_pkg::dbs_step_e step_q, step_d;
    logic bdm_q, frz_q, stp_q, hs_q, cis_q;
    logic stop_f_q, wait_f_q, nr_f_q;
    logic [4:0] lack_q;
    logic lack_o_q, req_q, we_q;
    logic [15:0] addr_q;
    logic [7:0] wd_q;
    logic avw_q;
    logic [31:0] avr_q;
    logic go_step, set_stop, set_wait, lack_go;

    // Link side: the serial clock domain gets its own copy of the reset.
    always_ff @(posedge i_dsclk)
    begin
        lr_s1_q <= i_rst;
        lr_s2_q <= lr_s1_q;
    end

    // Link side: latch the command and its data byte, flag them by toggles.
    always_ff @(posedge i_dsclk)
    begin
        if (lr_s2_q)
        begin
            l_op_q <= dbs_pkg::OP_NONE;
            l_addr_q <= 16'h0000;
            l_data_q <= 8'h00;
            l_rq_q <= 1'b0;
            l_fe_q <= 1'b0;
        end
        else
        begin
            if (i_lnk_cmd_stb)
            begin
                l_op_q <= i_lnk_op;
                l_addr_q <= i_lnk_addr;
                l_data_q <= i_lnk_data;
                l_rq_q <= ~l_rq_q;
            end
            if (i_lnk_fetch_stb)
                l_fe_q <= ~l_fe_q;
        end
    end

    // Link side: the completion toggle returns and releases the read byte.
    always_ff @(posedge i_dsclk)
    begin
        if (lr_s2_q)
        begin
            l_dn1_q <= 1'b0;
            l_dn2_q <= 1'b0;
            l_dn3_q <= 1'b0;
            l_rdata_q <= 8'h00;
            l_rv_q <= 1'b0;
        end
        else
        begin
            l_dn1_q <= dn_q;
            l_dn2_q <= l_dn1_q;
            l_dn3_q <= l_dn2_q;
            l_rv_q <= l_dn2_q ^ l_dn3_q;
            if (l_dn2_q ^ l_dn3_q)
                l_rdata_q <= rdata_q;
        end
    end

    assign o_lnk_rdata = l_rdata_q;
    assign o_lnk_rvalid = l_rv_q;

    // Core side: bring the link toggles across with three flops each.
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            rq1_q <= 1'b0;
            rq2_q <= 1'b0;
            rq3_q <= 1'b0;
            fe1_q <= 1'b0;
            fe2_q <= 1'b0;
            fe3_q <= 1'b0;
        end
        else
        begin
            rq1_q <= l_rq_q;
            rq2_q <= rq1_q;
            rq3_q <= rq2_q;
            fe1_q <= l_fe_q;
            fe2_q <= fe1_q;
            fe3_q <= fe2_q;
        end
    end

    // Command decode; the latched link fields are stable once the toggle lands.
    wire new_cmd = rq2_q ^ rq3_q;
    wire fetch_ev = fe2_q ^ fe3_q;
    wire is_acc = (l_op_q == dbs_pkg::OP_READ) | (l_op_q == dbs_pkg::OP_WRITE);
    wire new_acc = new_cmd & is_acc & (acc_q == dbs_pkg::A_IDLE);
    wire new_step = new_cmd & (l_op_q == dbs_pkg::OP_STEP);
    wire busy = acc_q != dbs_pkg::A_IDLE;
    wire acc_done = req_q & i_bus_ready;

    // Avalon decode: one wait state, then the access completes.
    wire av_req = i_avs_read | i_avs_write;
    wire av_take = av_req & ~avw_q;
    wire wr_ctrl = av_take & i_avs_write & (i_avs_address == dbs_pkg::CTRL_OFS);
    wire wr_stat = av_take & i_avs_write & (i_avs_address == dbs_pkg::STAT_OFS);
    wire enter_w = wr_ctrl & i_avs_writedata[dbs_pkg::CTRL_ENTER];
    wire go_w = wr_ctrl & i_avs_writedata[dbs_pkg::CTRL_GO];
    wire clr_stop = wr_stat & i_avs_writedata[dbs_pkg::STAT_STOP];
    wire clr_wait = wr_stat & i_avs_writedata[dbs_pkg::STAT_WAIT];
    wire clr_nr = wr_stat & i_avs_writedata[dbs_pkg::STAT_NR];
    wire [31:0] ctrl_rd = {30'h0, cis_q, hs_q};
    wire [31:0] stat_rd = {27'h0, lack_o_q, nr_f_q, wait_f_q, stop_f_q, bdm_q};
    wire [31:0] rd_mux = (i_avs_address == dbs_pkg::CTRL_OFS) ? ctrl_rd :
        (i_avs_address == dbs_pkg::STAT_OFS) ? stat_rd : 32'h0;

    // Access sequencer: decode cycle, optional wait for a free cycle, bus.
    always_comb
    begin
        acc_d = acc_q;
        case (acc_q)
            dbs_pkg::A_IDLE:
                if (new_acc)
                    acc_d = dbs_pkg::A_DEC;
            dbs_pkg::A_DEC:
                acc_d = (hs_q & ~i_bus_free) ? dbs_pkg::A_ARB
                    : dbs_pkg::A_BUS;
            dbs_pkg::A_ARB:
                if (i_bus_free)
                    acc_d = dbs_pkg::A_BUS;
            dbs_pkg::A_BUS:
                if (i_bus_ready)
                    acc_d = dbs_pkg::A_IDLE;
            default:
                acc_d = dbs_pkg::A_IDLE;
        endcase
    end

    // Execution control: single steps and the stop and wait corners.
    always_comb
    begin
        step_d = step_q;
        go_step = 1'b0;
        set_stop = 1'b0;
        set_wait = 1'b0;
        lack_go = 1'b0;
        case (step_q)
            dbs_pkg::S_USER:
                if (enter_w)
                    step_d = dbs_pkg::S_ACTIVE;
            dbs_pkg::S_ACTIVE:
                if (new_step)
                begin
                    step_d = dbs_pkg::S_RUN;
                    go_step = 1'b1;
                end
                else if (go_w)
                    step_d = dbs_pkg::S_USER;
            dbs_pkg::S_RUN:
                if (i_cpu_stop)
                begin
                    step_d = dbs_pkg::S_STOP;
                    set_stop = hs_q & cis_q;
                    lack_go = hs_q & cis_q;
                end
                else if (i_cpu_wait)
                begin
                    step_d = dbs_pkg::S_WAIT;
                    set_wait = 1'b1;
                    lack_go = hs_q;
                end
                else if (i_cpu_retire)
                    step_d = dbs_pkg::S_ACTIVE;
            dbs_pkg::S_STOP:
                if (i_irq_wake)
                    step_d = dbs_pkg::S_ACTIVE;
            dbs_pkg::S_WAIT:
                if (i_irq_wake)
                    step_d = dbs_pkg::S_ACTIVE;
            default:
                step_d = dbs_pkg::S_USER;
        endcase
    end

    wire bdm_d = step_d == dbs_pkg::S_ACTIVE;
    wire set_nr = (fetch_ev & busy) | set_wait;
    wire [4:0] lack_d = lack_go ? dbs_pkg::LACK_CYC
        : (lack_q != 5'h00) ? lack_q - 5'h01 : 5'h00;

    // State and sticky flags; a set in the clearing cycle wins.
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            acc_q <= dbs_pkg::A_IDLE;
            step_q <= dbs_pkg::S_USER;
            bdm_q <= 1'b0;
            frz_q <= 1'b0;
            stp_q <= 1'b0;
            stop_f_q <= 1'b0;
            wait_f_q <= 1'b0;
            nr_f_q <= 1'b0;
            lack_q <= 5'h00;
            lack_o_q <= 1'b0;
        end
        else
        begin
            acc_q <= acc_d;
            step_q <= step_d;
            bdm_q <= bdm_d;
            frz_q <= bdm_d;
            stp_q <= go_step;
            stop_f_q <= set_stop | (stop_f_q & ~clr_stop);
            wait_f_q <= set_wait | (wait_f_q & ~clr_wait);
            nr_f_q <= set_nr | (nr_f_q & ~clr_nr);
            lack_q <= lack_d;
            lack_o_q <= lack_d != 5'h00;
        end
    end

    // Bus side of an access; the request holds until the bus answers.
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            req_q <= 1'b0;
            we_q <= 1'b0;
            addr_q <= 16'h0000;
            wd_q <= 8'h00;
            rdata_q <= 8'h00;
            dn_q <= 1'b0;
        end
        else
        begin
            req_q <= acc_d == dbs_pkg::A_BUS;
            if (new_acc)
            begin
                we_q <= l_op_q == dbs_pkg::OP_WRITE;
                addr_q <= l_addr_q;
                wd_q <= l_data_q;
            end
            if (acc_done & ~we_q)
                rdata_q <= i_bus_rdata;
            if (acc_done)
                dn_q <= ~dn_q;
        end
    end

    // Register slave: control bits, status readback, waitrequest.
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            hs_q <= dbs_pkg::HS_RST;
            cis_q <= dbs_pkg::CIS_RST;
            avw_q <= 1'b1;
            avr_q <= 32'h0;
        end
        else
        begin
            avw_q <= ~(av_req & avw_q);
            if (av_req & avw_q & i_avs_read)
                avr_q <= rd_mux;
            if (wr_ctrl)
            begin
                hs_q <= i_avs_writedata[dbs_pkg::CTRL_HS];
                cis_q <= i_avs_writedata[dbs_pkg::CTRL_CIS];
            end
        end
    end

    assign o_avs_readdata = avr_q;
    assign o_avs_waitrequest = avw_q;
    assign o_bus_req = req_q;
    assign o_bus_we = we_q;
    assign o_bus_addr = addr_q;
    assign o_bus_wdata = wd_q;
    assign o_dbg_active = bdm_q;
    assign o_freeze = frz_q;
    assign o_cpu_step = stp_q;
    assign o_long_ack = lack_o_q;

    // Checks on the core clock.
    property p_direct;
        @(posedge i_mclk) disable iff (i_rst)
        new_acc & ~hs_q |=> ~o_bus_req ##1 o_bus_req;
    endproperty
    a_direct: assert property (p_direct) else $error("direct access late");

    property p_arb;
        @(posedge i_mclk) disable iff (i_rst)
        acc_q == dbs_pkg::A_ARB & ~i_bus_free |=> ~o_bus_req;
    endproperty
    a_arb: assert property (p_arb) else $error("bus taken while busy");

    property p_nr;
        @(posedge i_mclk) disable iff (i_rst)
        fetch_ev & busy |=> nr_f_q;
    endproperty
    a_nr: assert property (p_nr) else $error("no-response not set");

    property p_hold;
        @(posedge i_mclk) disable iff (i_rst)
        o_bus_req & ~i_bus_ready |=> o_bus_req & $stable(o_bus_addr);
    endproperty
    a_hold: assert property (p_hold) else $error("access aborted");

    property p_step;
        @(posedge i_mclk) disable iff (i_rst)
        o_dbg_active & new_step |=> o_cpu_step & ~o_dbg_active ##1 ~o_cpu_step;
    endproperty
    a_step: assert property (p_step) else $error("step not launched");

    property p_ret;
        @(posedge i_mclk) disable iff (i_rst)
        step_q == dbs_pkg::S_RUN & i_cpu_retire & ~i_cpu_stop & ~i_cpu_wait
        |=> o_dbg_active;
    endproperty
    a_ret: assert property (p_ret) else $error("no return to debug");

    property p_frz;
        @(posedge i_mclk) disable iff (i_rst)
        o_dbg_active |-> o_freeze;
    endproperty
    a_frz: assert property (p_frz) else $error("freeze missing");

    property p_stop;
        @(posedge i_mclk) disable iff (i_rst)
        step_q == dbs_pkg::S_RUN & i_cpu_stop & hs_q & cis_q
        |=> o_long_ack [*8] ##0 stop_f_q;
    endproperty
    a_stop: assert property (p_stop) else $error("stop ack wrong");

    property p_wait;
        @(posedge i_mclk) disable iff (i_rst)
        step_q == dbs_pkg::S_RUN & ~i_cpu_stop & i_cpu_wait
        |=> wait_f_q & nr_f_q & ~o_dbg_active & (o_long_ack == $past(hs_q));
    endproperty
    a_wait: assert property (p_wait) else $error("wait step wrong");

    property p_wake;
        @(posedge i_mclk) disable iff (i_rst)
        step_q == dbs_pkg::S_WAIT & i_irq_wake & ~o_long_ack
        |=> o_dbg_active & ~o_long_ack;
    endproperty
    a_wake: assert property (p_wake) else $error("wake wrong");

    c_read: cover property (@(posedge i_mclk) acc_done & ~we_q);
    c_late: cover property (@(posedge i_mclk) fetch_ev & busy);
    c_wait: cover property (@(posedge i_mclk)
        step_q == dbs_pkg::S_WAIT ##1 step_q == dbs_pkg::S_ACTIVE);

endmodule

/* File: sim/dbs_host_model.sv */
`timescale 1ns/1ns
// Behavioural debug host that drives the link side in the serial domain.
module dbs_host_model
(
    input logic i_dsclk,
    input logic i_rvalid,
    input logic [7:0] i_rdata,
    output logic o_cmd_stb,
    output logic [1:0] o_op,
    output logic [15:0] o_addr,
    output logic [7:0] o_data,
    output logic o_fetch_stb
);
    // Lines start idle at time zero.
    initial
    begin
        o_cmd_stb = 1'b0;
        o_fetch_stb = 1'b0;
        o_op = 2'h3;
        o_addr = 16'h0000;
        o_data = 8'h00;
    end

    // Sends a command byte with its data byte, then scrambles the lines.
    task automatic send(input logic [1:0] op, input logic [15:0] a,
        input logic [7:0] d);
        @(posedge i_dsclk);
        o_cmd_stb <= 1'b1;
        o_op <= op;
        o_addr <= a;
        o_data <= d;
        @(posedge i_dsclk);
        o_cmd_stb <= 1'b0;
        o_op <= ~op;
        o_addr <= ~a;
        o_data <= ~d;
    endtask

    // Starts data retrieval after the given number of serial cycles.
    task automatic fetch(input int dly);
        repeat (dly) @(posedge i_dsclk);
        o_fetch_stb <= 1'b1;
        @(posedge i_dsclk);
        o_fetch_stb <= 1'b0;
    endtask

    // Waits for the completion pulse and takes the byte it carries.
    task automatic collect(output logic [7:0] d, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        d = 8'h00;
        while (ok == 1'b0 && n < 200)
        begin
            @(negedge i_dsclk);
            if (i_rvalid === 1'b1)
            begin
                ok = 1'b1;
                d = i_rdata;
            end
            n++;
        end
    endtask
endmodule

/* File: sim/testbench.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic i_dsclk = 1'b0;
    logic [3:0] i_avs_address = 4'h0;
    logic i_avs_read = 1'b0;
    logic i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [31:0] o_avs_readdata, rq;
    logic o_avs_waitrequest, o_lnk_rvalid, o_bus_req, o_bus_we;
    logic i_lnk_cmd_stb, i_lnk_fetch_stb, o_dbg_active, o_freeze;
    logic o_cpu_step, o_long_ack;
    logic [1:0] i_lnk_op;
    logic [15:0] i_lnk_addr, o_bus_addr;
    logic [7:0] i_lnk_data, o_lnk_rdata, o_bus_wdata;
    logic [7:0] i_bus_rdata = 8'h00;
    logic i_bus_free = 1'b0;
    logic i_bus_ready = 1'b0;
    logic i_cpu_retire = 1'b0;
    logic i_cpu_stop = 1'b0;
    logic i_cpu_wait = 1'b0;
    logic i_irq_wake = 1'b0;
    int mismatches = 0;
    int checked = 0;
    int lack_cnt = 0;

    dbs_debug_step dut_u
    (
        .i_mclk, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write,
        .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .i_dsclk,
        .i_lnk_cmd_stb, .i_lnk_op, .i_lnk_addr, .i_lnk_data,
        .i_lnk_fetch_stb, .o_lnk_rdata, .o_lnk_rvalid, .o_bus_req,
        .o_bus_we, .o_bus_addr, .o_bus_wdata, .i_bus_free, .i_bus_ready,
        .i_bus_rdata, .o_dbg_active, .o_freeze, .o_cpu_step,
        .i_cpu_retire, .i_cpu_stop, .i_cpu_wait, .i_irq_wake, .o_long_ack
    );

    dbs_host_model h_u
    (
        .i_dsclk(i_dsclk),
        .i_rvalid(o_lnk_rvalid),
        .i_rdata(o_lnk_rdata),
        .o_cmd_stb(i_lnk_cmd_stb),
        .o_op(i_lnk_op),
        .o_addr(i_lnk_addr),
        .o_data(i_lnk_data),
        .o_fetch_stb(i_lnk_fetch_stb)
    );

    // Core clock, and a 15 ns link clock with its own phase.
    always #5 i_mclk = ~i_mclk;
    initial
    begin
        #3;
        forever
        begin
            #7 i_dsclk = ~i_dsclk;
            #8 i_dsclk = ~i_dsclk;
        end
    end

    // Counts the core cycles for which the long acknowledge stands.
    always @(posedge i_mclk)
    begin
        if (o_long_ack === 1'b1)
            lack_cnt <= lack_cnt + 1;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("mismatches=%0d checked=%0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // One Avalon transfer, held until waitrequest is seen low.
    task automatic av(input logic wr, input logic [3:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_mclk);
        i_avs_address <= a;
        i_avs_write <= wr;
        i_avs_read <= ~wr;
        i_avs_writedata <= d;
        do
        begin
            @(negedge i_mclk);
            n++;
        end
        while (o_avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20)
        begin
            mismatches++;
            print_verdict();
        end
        rq = o_avs_readdata;
        @(posedge i_mclk);
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
    endtask

    // Pulses one CPU event input: retire, stop, wait or wake.
    task automatic pulse(input int k);
        @(posedge i_mclk);
        case (k)
            0: i_cpu_retire <= 1'b1;
            1: i_cpu_stop <= 1'b1;
            2: i_cpu_wait <= 1'b1;
            default: i_irq_wake <= 1'b1;
        endcase
        @(posedge i_mclk);
        {i_cpu_retire, i_cpu_stop, i_cpu_wait, i_irq_wake} <= 4'h0;
        repeat (3) @(negedge i_mclk);
    endtask

    // Plays the internal bus: checks the request, stretches, completes.
    task automatic bus_serve(input int st, input logic we,
        input logic [15:0] a, input logic [7:0] d);
        int n;
        n = 0;
        while (o_bus_req !== 1'b1 && n < 40)
        begin
            @(negedge i_mclk);
            n++;
        end
        `CHK(o_bus_we, we)
        `CHK(o_bus_addr, a)
        if (we)
            `CHK(o_bus_wdata, d)
        repeat (st) @(posedge i_mclk);
        @(negedge i_mclk);
        `CHK(o_bus_req, 1'b1)
        @(posedge i_mclk);
        i_bus_ready <= 1'b1;
        i_bus_rdata <= d;
        @(posedge i_mclk);
        i_bus_ready <= 1'b0;
        i_bus_rdata <= ~d;
    endtask

    // Link access; an early fetch races the stretched bus cycle.
    task automatic access(input logic [1:0] op, input logic [15:0] a,
        input logic [7:0] d, input int st, input logic early);
        logic [7:0] got;
        logic ok;
        h_u.send(op, a, d);
        fork
            begin
                if (early)
                    h_u.fetch(0);
                h_u.collect(got, ok);
                if (!early)
                    h_u.fetch(16);
            end
            bus_serve(st, op == dbs_pkg::OP_WRITE, a, d);
        join
        `CHK(ok, 1'b1)
        if (op == dbs_pkg::OP_READ)
            `CHK(got, d)
    endtask

    // Issues a step and answers it with the given CPU event.
    task automatic step_to(input int k);
        int n;
        n = 0;
        h_u.send(dbs_pkg::OP_STEP, 16'h0000, 8'h00);
        while (o_cpu_step !== 1'b1 && n < 40)
        begin
            @(negedge i_mclk);
            n++;
        end
        `CHK(o_dbg_active, 1'b0)
        pulse(k);
    endtask

    // Main sequence of scenarios.
    initial
    begin
        repeat (12) @(posedge i_mclk);
        i_rst <= 1'b0;
        av(1'b0, dbs_pkg::CTRL_OFS, 32'h0);
        `CHK(rq, 32'h0)
        av(1'b1, 4'h8, 32'hFFFFFFFF);
        av(1'b0, 4'h8, 32'h0);
        `CHK(rq, 32'h0)
        `CHK(o_freeze, 1'b0)
        av(1'b1, dbs_pkg::CTRL_OFS, 32'h4);
        repeat (3) @(negedge i_mclk);
        `CHK(o_dbg_active, 1'b1)
        `CHK(o_freeze, 1'b1)
        access(dbs_pkg::OP_WRITE, 16'h1234, 8'h5A, 0, 1'b0);
        access(dbs_pkg::OP_READ, 16'h2345, 8'hC3, 3, 1'b1);
        av(1'b0, dbs_pkg::STAT_OFS, 32'h0);
        `CHK(rq[4:0], 5'h09)
        av(1'b1, dbs_pkg::STAT_OFS, 32'h8);
        access(dbs_pkg::OP_READ, 16'h3456, 8'h96, 0, 1'b0);
        av(1'b0, dbs_pkg::STAT_OFS, 32'h0);
        `CHK(rq[4:0], 5'h01)
        // Handshake on: the access must wait until a free cycle is offered.
        av(1'b1, dbs_pkg::CTRL_OFS, 32'h1);
        fork
            access(dbs_pkg::OP_READ, 16'h5678, 8'h3C, 0, 1'b0);
            begin
                repeat (20) @(negedge i_mclk);
                `CHK(o_bus_req, 1'b0)
                @(posedge i_mclk);
                i_bus_free <= 1'b1;
            end
        join
        @(posedge i_mclk);
        i_bus_free <= 1'b0;
        repeat (2)
        begin
            step_to(0);
            `CHK(o_dbg_active, 1'b1)
        end
        av(1'b1, dbs_pkg::CTRL_OFS, 32'h3);
        lack_cnt = 0;
        step_to(1);
        repeat (24) @(negedge i_mclk);
        `CHK(lack_cnt, 16)
        av(1'b0, dbs_pkg::STAT_OFS, 32'h0);
        `CHK(rq[4:0], 5'h02)
        pulse(3);
        `CHK(o_dbg_active, 1'b1)
        av(1'b1, dbs_pkg::STAT_OFS, 32'h2);
        av(1'b1, dbs_pkg::CTRL_OFS, 32'h0);
        lack_cnt = 0;
        step_to(2);
        av(1'b0, dbs_pkg::STAT_OFS, 32'h0);
        `CHK(rq[4:0], 5'h0C)
        access(dbs_pkg::OP_WRITE, 16'h4567, 8'hA5, 0, 1'b0);
        pulse(3);
        `CHK(o_dbg_active, 1'b1)
        `CHK(lack_cnt, 0)
        print_verdict();
    end

    // Cuts a hang short.
    initial
    begin
        #100000;
        mismatches++;
        print_verdict();
    end
endmodule
